// *** hdl/dtc_consts.svh ***
// Register offsets, field positions, reset values and widths of the dual timer
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_ADDR_W         4
`define DTC_OFF_LO_MATCH   4'h0
`define DTC_OFF_LO_PWIDTH  4'h1
`define DTC_OFF_LO_CTRL    4'h2
`define DTC_OFF_HI_MATCH   4'h3
`define DTC_OFF_HI_PWIDTH  4'h4
`define DTC_OFF_HI_CTRL    4'h5
`define DTC_OFF_CONFIG     4'h6
`define DTC_OFF_STATUS     4'h7
`define DTC_OFF_MASK       4'h8
`define DTC_OFF_LO_COUNT   4'h9
`define DTC_OFF_HI_COUNT   4'hA

// Control register layout: [7] flip-flop init, [6:4] clock, [3] run, [2:0] mode
`define DTC_CTRL_FF        7
`define DTC_CTRL_CK_HI     6
`define DTC_CTRL_CK_LO     4
`define DTC_CTRL_RUN       3
`define DTC_CTRL_MD_HI     2
`define DTC_CTRL_MD_LO     0

// Config register: [0] prescaler source, [1] slow/sleep power state
`define DTC_CFG_PSRC       0
`define DTC_CFG_SLOW       1

// Status/mask: [0] lower match, [1] upper match
`define DTC_ST_LO          0
`define DTC_ST_HI          1

`define DTC_RST_REG        8'h00
`define DTC_RST_CFG        2'h0
`define DTC_RST_ST         2'h0
`define DTC_PRESC_W        11
`define DTC_SYNC_W         3

`endif

// *** hdl/dtc_pkg.sv ***
// Types shared by the dual timer design
package dtc_pkg;
	typedef enum logic [2:0] {
		CK_SLOW_TAP,
		CK_FC_DIV128,
		CK_FC_DIV32,
		CK_FC_DIV8,
		CK_FS,
		CK_FC_DIV2,
		CK_FC,
		CK_EXT_PIN
	} dtc_clk_sel_t;

	typedef enum logic [2:0] {
		MD_TIMER8,
		MD_DIVIDER8,
		MD_PWM8,
		MD_CASCADE,
		MD_TIMER16,
		MD_WARMUP,
		MD_PWM16,
		MD_PULSEGEN16
	} dtc_mode_t;
endpackage

// *** hdl/dtc_timer.sv ***
// Dual cascadable 8-bit timer/counter with control, compare and interrupt logic
//
// Functional notes
// RULE_01 - Each counter has a control, a match and a pulse-width register of 8 bits.
// RULE_02 - Software leaves the match register alone while its counter runs.
// RULE_03 - Pulse width untouched while running, except in 8- or 16-bit PWM modes.
// RULE_04 - Clock code picks a prescaled tap, fs, fc/2, fc or the event pin.
// RULE_05 - Code 000 is fc/2^11 or fs/2^3; slow states allow only 000,100,111,110.
// RULE_06 - Lower counter uses fc in slow states only for high-frequency warm-up.
// RULE_07 - Run bit 0 stops and clears the count; 1 starts counting.
// RULE_08 - Lower mode: timer, divider, PWM, or cascaded 16-bit.
// RULE_09 - Upper mode: 8-bit timer/divider/PWM, reserved, 16-bit timer/warm-up/PWM/pulses.
// RULE_10 - Mode, clock and flip-flop fields stay fixed while running.
// RULE_11 - Stop write keeps those fields; start write may load them too.
// RULE_12 - Cascade needs lower mode 011 and upper mode chooses the function.
// RULE_13 - Cascade count source is the lower clock select.
// RULE_14 - Cascade run and flip-flop level follow the upper register.
// RULE_15 - Timer match raises interrupt, clears count and keeps counting.
// RULE_16 - Upper counter in 16-bit modes clocks on lower overflow.
// RULE_17 - Warm-up match value must lie in 256 to 65535.
// RULE_18 - Flip-flop bit sets the output start level, 0 low, 1 high.
// RULE_19 - Control register is 8 bits: flip-flop, clock, run, mode.
`include "dtc_consts.svh"

module dtc_timer (
	// Clock, reset, enable
	input  wire logic                    CLOCK,
	input  wire logic                    RST,
	input  wire logic                    CE,
	// Register port
	input  wire logic [`DTC_ADDR_W-1:0]  ADDR,
	input  wire logic [7:0]              WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [7:0]              RDATA,
	// Clock sources, one-cycle enables on CLOCK
	input  wire logic                    FC_TICK,
	input  wire logic                    FS_TICK,
	// Event pins
	input  wire logic                    LO_EVENT_PIN,
	input  wire logic                    HI_EVENT_PIN,
	// Outputs
	output logic                         LO_TIMER_OUT,
	output logic                         HI_TIMER_OUT,
	output logic                         IRQ
);

	// --------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------
	logic [7:0]  lo_match_ff, lo_pwidth_ff, lo_ctrl_ff;
	logic [7:0]  hi_match_ff, hi_pwidth_ff, hi_ctrl_ff;
	logic [1:0]  cfg_ff;
	logic [1:0]  status_ff;
	logic [1:0]  mask_ff;
	logic [7:0]  lo_cnt_ff, hi_cnt_ff;
	logic        lo_out_ff, hi_out_ff;
	logic [`DTC_PRESC_W-1:0] fc_div_ff;
	logic [2:0]  fs_div_ff;
	logic [`DTC_SYNC_W-1:0] lo_pin_sync_ff, hi_pin_sync_ff;
	logic        lo_pin_lvl_ff, hi_pin_lvl_ff;

	logic        wr_lo_ctrl, wr_hi_ctrl;
	logic        cascade, hi_is_16;
	logic        lo_run, hi_run;
	logic        lo_tick, hi_tick;
	logic        lo_pin_rise, hi_pin_rise;
	logic        lo_pin_stable, hi_pin_stable;
	logic        lo_match, hi_match, match16;
	logic        lo_overflow;
	logic        lo_event, hi_event;
	logic [1:0]  nxt_status;
	dtc_pkg::dtc_mode_t    hi_mode;

	assign wr_lo_ctrl = CE && WR && (ADDR == `DTC_OFF_LO_CTRL);
	assign wr_hi_ctrl = CE && WR && (ADDR == `DTC_OFF_HI_CTRL);

	// see RULE_01 see RULE_19
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lo_match_ff  <= `DTC_RST_REG;
			lo_pwidth_ff <= `DTC_RST_REG;
			lo_ctrl_ff   <= `DTC_RST_REG;
			hi_match_ff  <= `DTC_RST_REG;
			hi_pwidth_ff <= `DTC_RST_REG;
			hi_ctrl_ff   <= `DTC_RST_REG;
			cfg_ff       <= `DTC_RST_CFG;
			mask_ff      <= `DTC_RST_ST;
		end else if (CE && WR) begin
			unique case (ADDR)
				`DTC_OFF_LO_MATCH:  lo_match_ff  <= WDATA;
				`DTC_OFF_LO_PWIDTH: lo_pwidth_ff <= WDATA;
				`DTC_OFF_LO_CTRL:   lo_ctrl_ff   <= WDATA;
				`DTC_OFF_HI_MATCH:  hi_match_ff  <= WDATA;
				`DTC_OFF_HI_PWIDTH: hi_pwidth_ff <= WDATA;
				`DTC_OFF_HI_CTRL:   hi_ctrl_ff   <= WDATA;
				`DTC_OFF_CONFIG:    cfg_ff       <= WDATA[1:0];
				`DTC_OFF_MASK:      mask_ff      <= WDATA[1:0];
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------------
	// Mode decode
	// --------------------------------------------------------------------
	assign hi_mode  = dtc_pkg::dtc_mode_t'(hi_ctrl_ff[`DTC_CTRL_MD_HI:`DTC_CTRL_MD_LO]);
	// Upper modes 1xx are the 16-bit functions; lower mode 011 joins them
	assign cascade  = (lo_ctrl_ff[`DTC_CTRL_MD_HI:`DTC_CTRL_MD_LO]
		== 3'(dtc_pkg::MD_CASCADE)); // see RULE_08 see RULE_12
	assign hi_is_16 = hi_ctrl_ff[`DTC_CTRL_MD_HI]; // see RULE_09
	// Reserved upper code 011 leaves the counter idle
	assign hi_run   = hi_ctrl_ff[`DTC_CTRL_RUN] && (hi_mode != dtc_pkg::MD_CASCADE);
	assign lo_run   = cascade ? hi_ctrl_ff[`DTC_CTRL_RUN]
		: lo_ctrl_ff[`DTC_CTRL_RUN]; // see RULE_14

	// --------------------------------------------------------------------
	// Prescaler and pin synchronisers
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fc_div_ff <= '0;
			fs_div_ff <= 3'h0;
		end else if (CE) begin
			if (FC_TICK)
				fc_div_ff <= fc_div_ff + 1'b1;
			if (FS_TICK)
				fs_div_ff <= fs_div_ff + 1'b1;
		end
	end

	// Three stages; a level counts only once the last two agree
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lo_pin_sync_ff <= '0;
			hi_pin_sync_ff <= '0;
			lo_pin_lvl_ff  <= 1'b0;
			hi_pin_lvl_ff  <= 1'b0;
		end else if (CE) begin
			lo_pin_sync_ff <= {lo_pin_sync_ff[1:0], LO_EVENT_PIN};
			hi_pin_sync_ff <= {hi_pin_sync_ff[1:0], HI_EVENT_PIN};
			if (lo_pin_stable)
				lo_pin_lvl_ff <= lo_pin_sync_ff[2];
			if (hi_pin_stable)
				hi_pin_lvl_ff <= hi_pin_sync_ff[2];
		end
	end

	assign lo_pin_stable = lo_pin_sync_ff[2] == lo_pin_sync_ff[1];
	assign hi_pin_stable = hi_pin_sync_ff[2] == hi_pin_sync_ff[1];
	assign lo_pin_rise   = lo_pin_stable && lo_pin_sync_ff[2] && !lo_pin_lvl_ff;
	assign hi_pin_rise   = hi_pin_stable && hi_pin_sync_ff[2] && !hi_pin_lvl_ff;

	// Tick of one source: each tap fires when its lower prescaler bits roll over
	function automatic logic src_tick(input logic [2:0] sel, input logic pin_rise);
		logic slow;
		logic r;
		slow = cfg_ff[`DTC_CFG_SLOW];
		r    = 1'b0;
		unique case (dtc_pkg::dtc_clk_sel_t'(sel)) // see RULE_04
			dtc_pkg::CK_SLOW_TAP: // see RULE_05
				r = (slow || cfg_ff[`DTC_CFG_PSRC]) ? (FS_TICK && &fs_div_ff)
					: (FC_TICK && &fc_div_ff);
			dtc_pkg::CK_FC_DIV128: r = !slow && FC_TICK && &fc_div_ff[6:0];
			dtc_pkg::CK_FC_DIV32:  r = !slow && FC_TICK && &fc_div_ff[4:0];
			dtc_pkg::CK_FC_DIV8:   r = !slow && FC_TICK && &fc_div_ff[2:0];
			dtc_pkg::CK_FS:        r = FS_TICK;
			dtc_pkg::CK_FC_DIV2:   r = !slow && FC_TICK && fc_div_ff[0];
			dtc_pkg::CK_FC:        r = FC_TICK;
			dtc_pkg::CK_EXT_PIN:   r = pin_rise;
		endcase
		return r;
	endfunction

	// Slow states keep fc only on the lower counter (warm-up use)
	logic lo_src, hi_src;
	assign lo_src  = src_tick(lo_ctrl_ff[`DTC_CTRL_CK_HI:`DTC_CTRL_CK_LO], lo_pin_rise);
	assign hi_src  = src_tick(hi_ctrl_ff[`DTC_CTRL_CK_HI:`DTC_CTRL_CK_LO], hi_pin_rise)
		&& !(cfg_ff[`DTC_CFG_SLOW]
		&& hi_ctrl_ff[`DTC_CTRL_CK_HI:`DTC_CTRL_CK_LO] == 3'(dtc_pkg::CK_FC)); // see RULE_05
	assign lo_tick = lo_run && lo_src; // see RULE_13

	// --------------------------------------------------------------------
	// Counters
	// --------------------------------------------------------------------
	// Cascade: lower wraps past FF, upper counts those wraps; in warm-up the
	// lower byte of the match takes no part in the comparison
	assign lo_overflow = lo_tick && (lo_cnt_ff == 8'hFF);
	assign hi_tick     = (cascade && hi_is_16) ? lo_overflow : (hi_run && hi_src); // see RULE_16
	assign match16     = (hi_cnt_ff == hi_match_ff)
		&& ((hi_mode == dtc_pkg::MD_WARMUP) || (lo_cnt_ff == lo_match_ff)); // see RULE_17
	assign lo_match    = lo_tick && (lo_cnt_ff == lo_match_ff);
	assign hi_match    = hi_tick && (hi_cnt_ff == hi_match_ff);

	logic pair_mode;
	assign pair_mode = cascade && hi_is_16;
	logic hit16;
	assign hit16     = pair_mode && lo_tick && match16;
	assign lo_event  = !pair_mode && lo_match;
	assign hi_event  = pair_mode ? hit16 : hi_match;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lo_cnt_ff <= 8'h00;
		end else if (CE) begin
			if (!lo_run)
				lo_cnt_ff <= 8'h00; // see RULE_07
			else if (hit16 || lo_event)
				lo_cnt_ff <= 8'h00; // see RULE_15
			else if (lo_tick)
				lo_cnt_ff <= lo_cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			hi_cnt_ff <= 8'h00;
		end else if (CE) begin
			if (!hi_run)
				hi_cnt_ff <= 8'h00; // see RULE_07
			else if (hit16 || (!pair_mode && hi_match))
				hi_cnt_ff <= 8'h00; // see RULE_15
			else if (hi_tick)
				hi_cnt_ff <= hi_cnt_ff + 8'h01;
		end
	end

	// --------------------------------------------------------------------
	// Output flip-flops: start level loaded while stopped, toggled on match in divider mode 001 only
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lo_out_ff <= 1'b0;
		end else if (CE) begin
			if (!lo_run)
				lo_out_ff <= cascade ? hi_ctrl_ff[`DTC_CTRL_FF]
					: lo_ctrl_ff[`DTC_CTRL_FF]; // see RULE_18 see RULE_14
			else if (lo_event
				&& lo_ctrl_ff[`DTC_CTRL_MD_HI:`DTC_CTRL_MD_LO] == 3'(dtc_pkg::MD_DIVIDER8))
				lo_out_ff <= !lo_out_ff;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			hi_out_ff <= 1'b0;
		end else if (CE) begin
			if (!hi_run)
				hi_out_ff <= hi_ctrl_ff[`DTC_CTRL_FF]; // see RULE_18
			else if (hi_event && hi_mode == dtc_pkg::MD_DIVIDER8)
				hi_out_ff <= !hi_out_ff;
		end
	end

	assign LO_TIMER_OUT = lo_out_ff;
	assign HI_TIMER_OUT = hi_out_ff;

	// --------------------------------------------------------------------
	// Interrupt status: set wins over clear-on-read
	// --------------------------------------------------------------------
	always_comb begin
		nxt_status = status_ff;
		if (RD && ADDR == `DTC_OFF_STATUS)
			nxt_status = 2'h0;
		if (lo_event)
			nxt_status[`DTC_ST_LO] = 1'b1; // see RULE_15
		if (hi_event)
			nxt_status[`DTC_ST_HI] = 1'b1;
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			status_ff <= `DTC_RST_ST;
		else if (CE)
			status_ff <= nxt_status;
	end

	assign IRQ = |(status_ff & mask_ff);

	// --------------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (CE) begin
			RDATA <= 8'h00;
			if (RD) begin
				unique case (ADDR)
					`DTC_OFF_LO_MATCH:  RDATA <= lo_match_ff;
					`DTC_OFF_LO_PWIDTH: RDATA <= lo_pwidth_ff;
					`DTC_OFF_LO_CTRL:   RDATA <= lo_ctrl_ff;
					`DTC_OFF_HI_MATCH:  RDATA <= hi_match_ff;
					`DTC_OFF_HI_PWIDTH: RDATA <= hi_pwidth_ff;
					`DTC_OFF_HI_CTRL:   RDATA <= hi_ctrl_ff;
					`DTC_OFF_CONFIG:    RDATA <= {6'h00, cfg_ff};
					`DTC_OFF_STATUS:    RDATA <= {6'h00, status_ff};
					`DTC_OFF_MASK:      RDATA <= {6'h00, mask_ff};
					`DTC_OFF_LO_COUNT:  RDATA <= lo_cnt_ff;
					`DTC_OFF_HI_COUNT:  RDATA <= hi_cnt_ff;
					default:            RDATA <= 8'h00;
				endcase
			end
		end
	end

endmodule

// *** tb/dtc_timer_props.sv ***
// Port-level checks of the dual timer, bound to its top module
module dtc_timer_props (
	// Clock, reset, enable
	input wire logic       CLOCK,
	input wire logic       RST,
	input wire logic       CE,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	// Sources and pins
	input wire logic       FC_TICK,
	input wire logic       FS_TICK,
	input wire logic       LO_EVENT_PIN,
	input wire logic       HI_EVENT_PIN,
	// Outputs
	input wire logic       LO_TIMER_OUT,
	input wire logic       HI_TIMER_OUT,
	input wire logic       IRQ
);
	// -----
	// Properties
	// -----
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	AST_UNMAPPED_ZERO: assert property (RD && CE && ADDR > 4'hA |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	AST_READBACK: assert property (WR && CE && ADDR < 4'h6 ##2 RD && CE && ADDR == $past(ADDR, 2)
		|=> RDATA == $past(WDATA, 3)) else $error("register readback differs");
	AST_LO_STOP_CLR: assert property (WR && CE && ADDR == 4'h2 && !WDATA[3] && WDATA[2:0] != 3'h3
		##2 RD && CE && ADDR == 4'h9 |=> RDATA == 8'h00) else $error("lower count not cleared");
	AST_HI_STOP_CLR: assert property (WR && CE && ADDR == 4'h5 && !WDATA[3]
		##2 RD && CE && ADDR == 4'hA |=> RDATA == 8'h00) else $error("upper count not cleared");
	AST_LO_FF_LEVEL: assert property (WR && CE && ADDR == 4'h2 && !WDATA[3] && WDATA[2:0] != 3'h3
		|-> ##3 LO_TIMER_OUT == $past(WDATA[7], 3)) else $error("lower output level wrong");
	AST_HI_FF_LEVEL: assert property (WR && CE && ADDR == 4'h5 && !WDATA[3] && WDATA[2:0] != 3'h3
		|-> ##3 HI_TIMER_OUT == $past(WDATA[7], 3)) else $error("upper output level wrong");
	AST_MASK_OFF: assert property (WR && CE && ADDR == 4'h8 && WDATA[1:0] == 2'h0 |=> !IRQ)
		else $error("interrupt while masked");
	AST_IRQ_CLEARED: assert property ((!FC_TICK && !FS_TICK)[*3] ##0 RD && CE && ADDR == 4'h7
		|=> !IRQ) else $error("interrupt stays after status read");
endmodule

bind dtc_timer dtc_timer_props props_i (.CLOCK, .RST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.FC_TICK, .FS_TICK, .LO_EVENT_PIN, .HI_EVENT_PIN, .LO_TIMER_OUT, .HI_TIMER_OUT, .IRQ);

// *** tb/dual_8bit_timer_control_bench.sv ***
// Self-checking bench for the dual timer control block
module dual_8bit_timer_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       CLOCK = 0, RST = 1, CE = 1, WR = 0, RD = 0;
	logic       FC_TICK = 0, FS_TICK = 0, LO_EVENT_PIN = 0, HI_EVENT_PIN = 0;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA;
	logic       LO_TIMER_OUT, HI_TIMER_OUT, IRQ;
	int         mismatches = 0, checks = 0;
	// Lower count per run of 2048 fc ticks, match 254: normal codes, slow codes, fs/8 tap
	logic [7:0] exp_tab [17] = '{8'h01, 8'h10, 8'h40, 8'h01, 8'h28, 8'h04, 8'h08, 8'h05,
		8'h05, 8'h00, 8'h00, 8'h00, 8'h28, 8'h00, 8'h08, 8'h05, 8'h05};

	always #12.5 CLOCK = ~CLOCK;

	dtc_timer uut (.CLOCK, .RST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .FC_TICK, .FS_TICK,
		.LO_EVENT_PIN, .HI_EVENT_PIN, .LO_TIMER_OUT, .HI_TIMER_OUT, .IRQ);

	// -----
	// Access and check tasks
	// -----
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge CLOCK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask

	task automatic rd(logic [3:0] a, string nm, logic [7:0] e);
		@(posedge CLOCK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 chk(nm, e, RDATA);
	endtask

	// Fc ticks every cycle; fs ticks and five pin edges only in the first 40 cycles
	task automatic run_ticks(int n);
		for (int i = 0; i < n; i++) begin
			@(posedge CLOCK);
			FC_TICK <= 1'b1;
			FS_TICK <= i < 40;
			LO_EVENT_PIN <= i[2] && i < 40;
			HI_EVENT_PIN <= i[2] && i < 40;
		end
		@(posedge CLOCK);
		FC_TICK <= 1'b0;
		FS_TICK <= 1'b0;
		LO_EVENT_PIN <= 1'b0;
		HI_EVENT_PIN <= 1'b0;
		repeat (6) @(posedge CLOCK);
	endtask

	task automatic wait_irq;
		for (int i = 0; i < 20 && IRQ !== 1'b1; i++)
			@(posedge CLOCK);
		chk("irq", 8'h01, {7'h00, IRQ});
		if (IRQ !== 1'b1)
			complete_run;
	endtask

	// -----
	// Main sequence
	// -----
	initial begin
		repeat (12) @(posedge CLOCK);
		RST <= 1'b0;
		for (int a = 0; a < 11; a++)
			rd(a[3:0], "reset value", 8'h00);
		for (int a = 0; a < 6; a++) begin
			wr(a[3:0], 8'hA0 + a[7:0]);
			rd(a[3:0], "register", 8'hA0 + a[7:0]);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, "unmapped", 8'h00);
		wr(4'h8, 8'hFF);
		rd(4'h8, "mask", 8'h03);
		wr(4'h2, 8'h80);
		wr(4'h5, 8'h00);
		repeat (3) @(posedge CLOCK);
		chk("outputs", 8'h02, {6'h00, LO_TIMER_OUT, HI_TIMER_OUT});
		wr(4'h2, 8'h00);
		wr(4'h5, 8'h80);
		repeat (3) @(posedge CLOCK);
		chk("outputs", 8'h01, {6'h00, LO_TIMER_OUT, HI_TIMER_OUT});
		// Every clock code, normal and slow state, then the fs/8 tap
		wr(4'h0, 8'hFE);
		for (int k = 0; k < 17; k++) begin
			wr(4'h6, k == 16 ? 8'h01 : {6'h00, k[3], 1'b0});
			wr(4'h2, {1'b0, k[2:0], 4'h8});
			run_ticks(2048);
			rd(4'h9, "lo count", exp_tab[k]);
			wr(4'h2, {1'b0, k[2:0], 4'h0});
			rd(4'h9, "lo count stopped", 8'h00);
		end
		wr(4'h6, 8'h02);
		wr(4'h3, 8'hFE);
		wr(4'h5, 8'h68);
		run_ticks(2048);
		rd(4'hA, "hi count slow fc", 8'h00);
		wr(4'h5, 8'h60);
		wr(4'h6, 8'h00);
		chk("irq", 8'h01, {7'h00, IRQ});
		rd(4'h7, "status", 8'h01);
		chk("irq", 8'h00, {7'h00, IRQ});
		// Match, interrupt and masking
		wr(4'h0, 8'h03);
		wr(4'h2, 8'h68);
		run_ticks(3);
		rd(4'h9, "lo count", 8'h03);
		rd(4'h7, "status", 8'h00);
		run_ticks(1);
		wait_irq;
		rd(4'h9, "lo count", 8'h00);
		rd(4'h7, "status", 8'h01);
		wr(4'h8, 8'h00);
		run_ticks(4);
		chk("irq masked", 8'h00, {7'h00, IRQ});
		rd(4'h7, "status", 8'h01);
		wr(4'h2, 8'h60);
		// Cascade: lower clock, upper run bit, upper clocked by overflow
		wr(4'h3, 8'h01);
		wr(4'h0, 8'h02);
		wr(4'h2, 8'h63);
		wr(4'h5, 8'h6C);
		run_ticks(257);
		rd(4'h9, "cascade lo", 8'h01);
		rd(4'hA, "cascade hi", 8'h01);
		run_ticks(2);
		rd(4'h9, "cascade lo", 8'h00);
		rd(4'h7, "status", 8'h02);
		wr(4'h5, 8'h64);
		rd(4'hA, "cascade hi stopped", 8'h00);
		// Warm-up: combined match 01xx, only the upper byte is compared
		wr(4'h5, 8'h6D);
		run_ticks(257);
		rd(4'hA, "warm-up hi", 8'h00);
		rd(4'h7, "status", 8'h02);
		wr(4'h5, 8'h65);
		complete_run;
	end
endmodule
